// [pkg/chan_int_pkg.sv]
package chan_int_pkg;

    // Number of line channels served by this block.
    localparam int NUM_CHANNELS = 3;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] ENABLE_IDX_CH0   = 8'h01;
    localparam logic [7:0] ENABLE_IDX_CH1   = 8'h09;
    localparam logic [7:0] ENABLE_IDX_CH2   = 8'h11;
    localparam logic [7:0] STATUS_IDX_CH0   = 8'h02;
    localparam logic [7:0] STATUS_IDX_CH1   = 8'h0A;
    localparam logic [7:0] STATUS_IDX_CH2   = 8'h12;
    localparam logic [7:0] BLK_MASK_IDX     = 8'h20;
    localparam logic [7:0] BLK_STATUS_IDX   = 8'h21;

    // Field positions inside the enable and change-status registers.
    localparam int FIELD_FIFO_LIMIT  = 3;
    localparam int FIELD_LOCK_LOST   = 2;
    localparam int FIELD_SIGNAL_LOST = 1;
    localparam int FIELD_DRIVE_MON   = 0;
    localparam int FIELD_WIDTH       = 4;

    // Reset values.
    localparam logic [3:0]  ENABLE_RESET    = 4'h0;
    localparam logic [3:0]  STATUS_RESET    = 4'h0;
    localparam logic [2:0]  BLK_RESET       = 3'h0;
    localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

    // Bus encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic       HRESP_OKAY    = 1'b0;

    // One change event per monitored condition, bit order as in the registers.
    typedef struct packed {
        logic fifo_limit_alarm;
        logic receive_lock_lost;
        logic receive_signal_lost;
        logic drive_monitor_output;
    } condition_events_type;

    // Pending data phase of the bus slave.
    typedef enum logic [0:0] {
        PHASE_IDLE  = 1'b0,
        PHASE_WRITE = 1'b1
    } bus_phase_type;

    // Enable register index of a channel.
    function automatic logic [7:0] enable_idx(input int ch);
        unique case (ch)
            0: enable_idx = ENABLE_IDX_CH0;
            1: enable_idx = ENABLE_IDX_CH1;
            default: enable_idx = ENABLE_IDX_CH2;
        endcase
    endfunction

    // Change-status register index of a channel.
    function automatic logic [7:0] status_idx(input int ch);
        unique case (ch)
            0: status_idx = STATUS_IDX_CH0;
            1: status_idx = STATUS_IDX_CH1;
            default: status_idx = STATUS_IDX_CH2;
        endcase
    endfunction

endpackage

// [rtl/chan_event_latch.sv]
`timescale 1ns/1ps

module chan_event_latch
    import chan_int_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire condition_events_type events,
    input  wire logic                 read_clear,
    input  wire logic [3:0]           enable,
    output logic [3:0]                status,
    output logic                      irq
);

    logic [3:0] status_reg;
    logic [3:0] status_next;

    // RULE_07: latch and clear
    // A change arriving in the reading cycle survives, so no event is lost.
    always_comb begin
        status_next = (read_clear ? STATUS_RESET : status_reg) | events;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    assign status = status_reg;
    // RULE_08: request level
    assign irq = |(status_reg & enable);

    // RULE_02: fifo alarm interrupt
    fifo_limit_irq_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_02
        events.fifo_limit_alarm && enable[FIELD_FIFO_LIMIT] |=> irq)
        else $error("fifo limit change did not raise the request");

    // RULE_03: lock loss interrupt
    lock_lost_irq_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_03
        events.receive_lock_lost && enable[FIELD_LOCK_LOST] |=> irq)
        else $error("lock change did not raise the request");

    // RULE_04: signal loss interrupt
    signal_lost_irq_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_04
        events.receive_signal_lost && enable[FIELD_SIGNAL_LOST] |=> irq)
        else $error("signal change did not raise the request");

    // RULE_05: drive monitor interrupt
    drive_mon_irq_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_05
        events.drive_monitor_output && enable[FIELD_DRIVE_MON] |=> irq)
        else $error("drive monitor change did not raise the request");

    // RULE_07: cleared by read
    read_clears_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_07
        read_clear && events == STATUS_RESET |=> status == STATUS_RESET)
        else $error("change status not cleared by read");

    // RULE_08: request holds
    irq_holds_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_08
        irq && !read_clear |=> irq || enable != $past(enable))
        else $error("request dropped with latched change pending");

endmodule

// [rtl/chan_int_enable.sv]
// Contract
// RULE_01: Channel enable registers sit at index 0x01, 0x09, 0x11, eight bits.
// RULE_02: Enable bit 3 set: any fifo limit alarm change raises an interrupt.
// RULE_03: Enable bit 2 set: any receive lock loss change raises an interrupt.
// RULE_04: Enable bit 1 set: any receive signal loss change raises an interrupt.
// RULE_05: Enable bit 0 set: any drive monitor output change raises an interrupt.
// RULE_06: Enable bits 3..0 read and write; one permits, zero suppresses; reset zero.
// RULE_07: Each condition keeps a change latch, cleared when status is read.
// RULE_08: Channel request stays high while any enabled latched change remains.
`timescale 1ns/1ps

module chan_int_enable
    import chan_int_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    input  wire condition_events_type chan_events [NUM_CHANNELS],
    output logic [NUM_CHANNELS-1:0]   chan_irq,
    output logic                      irq
);

    // Bus state.
    bus_phase_type           phase_reg;
    bus_phase_type           phase_next;
    logic [7:0]              wr_idx_reg;
    logic [7:0]              wr_idx_next;
    logic [31:0]             hrdata_reg;
    logic [31:0]             hrdata_next;

    // Register state.
    logic [3:0]              enable_reg [NUM_CHANNELS];
    logic [3:0]              enable_next [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] blk_status_reg;
    logic [NUM_CHANNELS-1:0] blk_status_next;
    logic [NUM_CHANNELS-1:0] blk_mask_reg;
    logic [NUM_CHANNELS-1:0] blk_mask_next;

    // Decode helpers.
    logic                    addr_ok;
    logic                    rd_take;
    logic                    wr_take;
    logic [7:0]              addr_idx;
    logic                    wr_active;
    logic [NUM_CHANNELS-1:0] status_read;
    logic [3:0]              chan_status [NUM_CHANNELS];

    // Only whole aligned words inside the low map are decoded; size is not checked.
    assign addr_idx  = haddr[9:2];
    assign addr_ok   = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
    assign rd_take   = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
    assign wr_take   = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite && addr_ok;
    assign wr_active = (phase_reg == PHASE_WRITE);

    // A status read clears that channel's change latches on the address phase.
    always_comb begin
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            status_read[ch] = rd_take && addr_ok && (addr_idx == status_idx(ch));
        end
    end

    // Per-channel change latches and their gated requests.
    for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chan
        chan_event_latch u_latch (
            .clk        (clk),
            .nrst       (nrst),
            .events     (chan_events[g]),
            .read_clear (status_read[g]),
            .enable     (enable_reg[g]),
            .status     (chan_status[g]),
            .irq        (chan_irq[g])
        );
    end

    // Bus phase tracking; the slave never stalls, so hreadyout is always high.
    always_comb begin
        phase_next  = phase_reg;
        wr_idx_next = wr_idx_reg;
        if (hready) begin
            phase_next  = wr_take ? PHASE_WRITE : PHASE_IDLE;
            wr_idx_next = wr_take ? addr_idx : wr_idx_reg;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg  <= PHASE_IDLE;
            wr_idx_reg <= 8'h00;
        end else begin
            phase_reg  <= phase_next;
            wr_idx_reg <= wr_idx_next;
        end
    end

    // RULE_01: enable register decode
    // RULE_06: writable enable bits
    // Bits 7..4 of the written byte are dropped; they read back as zero.
    always_comb begin
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            enable_next[ch] = enable_reg[ch];
            if (wr_active && (wr_idx_reg == enable_idx(ch))) begin
                enable_next[ch] = hwdata[3:0];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
                enable_reg[ch] <= ENABLE_RESET;
            end
        end else begin
            for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
                enable_reg[ch] <= enable_next[ch];
            end
        end
    end

    // Block-level channel summary: sticky, write one to clear, and a new
    // request in the clearing cycle wins so an event is never dropped.
    always_comb begin
        blk_mask_next   = blk_mask_reg;
        blk_status_next = blk_status_reg;
        if (wr_active && (wr_idx_reg == BLK_MASK_IDX)) begin
            blk_mask_next = hwdata[NUM_CHANNELS-1:0];
        end
        if (wr_active && (wr_idx_reg == BLK_STATUS_IDX)) begin
            blk_status_next = blk_status_reg & ~hwdata[NUM_CHANNELS-1:0];
        end
        blk_status_next = blk_status_next | chan_irq;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blk_mask_reg   <= BLK_RESET;
            blk_status_reg <= BLK_RESET;
        end else begin
            blk_mask_reg   <= blk_mask_next;
            blk_status_reg <= blk_status_next;
        end
    end

    // Read data are built in the address phase and registered for the data
    // phase; the next enable and mask values are used so a read right behind a write to them sees it.
    always_comb begin
        hrdata_next = hrdata_reg;
        if (rd_take) begin
            hrdata_next = RDATA_RESET;
            if (addr_ok) begin
                for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
                    // RULE_01: enable readback
                    if (addr_idx == enable_idx(ch)) begin
                        hrdata_next = {28'h000_0000, enable_next[ch]};
                    end
                    if (addr_idx == status_idx(ch)) begin
                        hrdata_next = {28'h000_0000, chan_status[ch]};
                    end
                end
                if (addr_idx == BLK_MASK_IDX) begin
                    hrdata_next = {29'h000_0000, blk_mask_next};
                end
                if (addr_idx == BLK_STATUS_IDX) begin
                    hrdata_next = {29'h000_0000, blk_status_reg};
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hrdata_reg <= RDATA_RESET;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign irq       = |(blk_status_reg & blk_mask_reg);

    // RULE_01: channel 1 write
    enable_write_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_01
        wr_active && wr_idx_reg == ENABLE_IDX_CH1
        |=> enable_reg[1] == $past(hwdata[3:0]))
        else $error("channel 1 enable not written at its index");

    // RULE_06: stable without write
    enable_stable_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_06
        !wr_active |=> enable_reg[0] == $past(enable_reg[0]))
        else $error("enable bits changed without a write");

    // RULE_06: readback matches
    enable_readback_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_06
        rd_take && addr_ok && addr_idx == ENABLE_IDX_CH2 && !wr_active
        |=> hrdata == {28'h000_0000, enable_reg[2]})
        else $error("enable readback wrong");

    // RULE_08: summary follows request
    summary_sets_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_08
        chan_irq[0] |=> blk_status_reg[0])
        else $error("channel request not recorded in summary");

    // RULE_07: status read clears
    // The request is checked with the status in the cycle after the read, so a later event cannot mask a stale latch.
    status_clear_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_07
        status_read[0] && chan_events[0] == STATUS_RESET
        |=> chan_status[0] == STATUS_RESET && !chan_irq[0])
        else $error("status read left change latches set");

    // RULE_07: read before clear
    // Software must see what was latched, not the value left after the clear.
    read_before_clear_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_07
        status_read[1] |=> hrdata == {28'h000_0000, $past(chan_status[1])})
        else $error("status read did not return the latched changes");

    // RULE_01: channel 0 write
    enable_write0_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_01
        wr_active && wr_idx_reg == ENABLE_IDX_CH0
        |=> enable_reg[0] == $past(hwdata[3:0]))
        else $error("channel 0 enable not written at its index");

    // RULE_01: channel 2 write
    enable_write2_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_01
        wr_active && wr_idx_reg == ENABLE_IDX_CH2
        |=> enable_reg[2] == $past(hwdata[3:0]))
        else $error("channel 2 enable not written at its index");

    // RULE_06: other copies hold
    enable_hold_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_06
        !wr_active
        |=> enable_reg[1] == $past(enable_reg[1]) && enable_reg[2] == $past(enable_reg[2]))
        else $error("channel 1 or 2 enable changed without a write");

    // RULE_06: unused bits zero
    // Only four enable bits exist, so the upper bits of the word never carry data.
    enable_unused_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_06
        rd_take && addr_ok && addr_idx == ENABLE_IDX_CH0
        |=> hrdata[31:4] == 28'h000_0000)
        else $error("unused enable bits read as nonzero");

    // RULE_06: read data stand
    rdata_holds_a : assert property (@(posedge clk) disable iff (!nrst) // RULE_06
        !rd_take |=> hrdata == $past(hrdata))
        else $error("read data changed without a read");

endmodule

// [testbench/chan_int_enable_test.sv]
`timescale 1ns/1ps

module chan_int_enable_test;
    import chan_int_pkg::*;

    logic                 clk    = 1'b0;
    logic                 nrst   = 1'b0;
    logic                 hsel   = 1'b0;
    logic [31:0]          haddr  = 32'h0000_0000;
    logic [1:0]           htrans = 2'b00;
    logic                 hwrite = 1'b0;
    logic [2:0]           hsize  = 3'b010;
    logic [31:0]          hwdata = 32'h0000_0000;
    logic                 hready;
    logic                 hreadyout;
    logic [31:0]          hrdata;
    logic                 hresp;
    condition_events_type chan_events [NUM_CHANNELS] = '{default: '0};
    logic [2:0]           chan_irq;
    logic                 irq;
    logic [31:0]          rd;
    int                   miscompares = 0;
    int                   comparisons = 0;
    logic [7:0]           en_idx [3] = '{ENABLE_IDX_CH0, ENABLE_IDX_CH1, ENABLE_IDX_CH2};
    logic [7:0]           st_idx [3] = '{STATUS_IDX_CH0, STATUS_IDX_CH1, STATUS_IDX_CH2};

    // With a single slave its ready output is the bus ready.
    assign hready = hreadyout;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    chan_int_enable uut (
        .clk         (clk),
        .nrst        (nrst),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hwdata      (hwdata),
        .hready      (hready),
        .hreadyout   (hreadyout),
        .hrdata      (hrdata),
        .hresp       (hresp),
        .chan_events (chan_events),
        .chan_irq    (chan_irq),
        .irq         (irq)
    );

    // Compares one value and records any difference.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One single transfer; the wait has no fixed bound, only the watchdog ends it.
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wdata);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
    endtask

    // A one-cycle change pulse, then a settled look at the outputs.
    task automatic pulse(input int ch, input logic [3:0] ev);
        @(posedge clk);
        chan_events[ch] <= condition_events_type'(ev);
        @(posedge clk);
        chan_events[ch] <= '0;
        @(negedge clk);
    endtask

    // Registers and requests start cleared after reset.
    task automatic test_reset;
        for (int ch = 0; ch < 3; ch++) begin
            bus(en_idx[ch], 1'b0, 32'h0);
            check(rd, 32'h0000_0000, "enable reset");
        end
        check({29'h0, chan_irq}, 32'h0000_0000, "chan_irq reset");
        check({30'h0, hreadyout, irq}, 32'h0000_0002, "ready and irq reset");
    endtask

    // An event in the very cycle of the clearing read must survive it.
    task automatic test_read_race;
        bus(ENABLE_IDX_CH2, 1'b1, 32'h0000_0002);
        fork
            bus(STATUS_IDX_CH2, 1'b0, 32'h0);
            begin
                @(posedge clk);
                chan_events[2] <= condition_events_type'(4'h2);
                @(posedge clk);
                chan_events[2] <= '0;
            end
        join
        check(rd, 32'h0000_0000, "status before event");
        check({31'h0, chan_irq[2]}, 32'h1, "event kept over read");
        bus(STATUS_IDX_CH2, 1'b0, 32'h0);
        check(rd, 32'h0000_0002, "event kept in latch");
        bus(ENABLE_IDX_CH2, 1'b1, 32'h0);
    endtask

    // A reset in mid-run returns enables, latches and requests to zero.
    task automatic test_mid_reset;
        bus(BLK_MASK_IDX, 1'b1, 32'h0000_0007);
        bus(ENABLE_IDX_CH1, 1'b1, 32'h0000_000F);
        pulse(1, 4'hF);
        repeat (2) @(negedge clk);
        check({31'h0, irq}, 32'h1, "irq before reset");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        bus(ENABLE_IDX_CH1, 1'b0, 32'h0);
        check(rd, 32'h0000_0000, "enable after reset");
        bus(STATUS_IDX_CH1, 1'b0, 32'h0);
        check(rd, 32'h0000_0000, "status after reset");
        check({29'h0, chan_irq}, 32'h0000_0000, "requests after reset");
        check({31'h0, irq}, 32'h0, "irq after reset");
    endtask

    // Each copy keeps its own four bits; unused bits and unmapped places read zero.
    task automatic test_enable_rw;
        for (int ch = 0; ch < 3; ch++) begin
            bus(en_idx[ch], 1'b1, 32'hFFFF_FFF0 | (32'h0000_0005 << ch));
        end
        for (int ch = 0; ch < 3; ch++) begin
            bus(en_idx[ch], 1'b0, 32'h0);
            check(rd, (32'h0000_0005 << ch) & 32'h0000_000F, "enable readback");
        end
        bus(8'h3F, 1'b0, 32'h0);
        check(rd, 32'h0000_0000, "unmapped read");
    endtask

    // Every source alone raised when its bit is one; the other three, pulsed together with bits zero, suppressed.
    task automatic test_sources;
        logic [3:0] one;
        for (int ch = 0; ch < 3; ch++) begin
            for (int b = 0; b < 4; b++) begin
                one = 4'h1 << b;
                bus(en_idx[ch], 1'b1, {28'h0, one});
                pulse(ch, ~one);
                check({31'h0, chan_irq[ch]}, 32'h0, "disabled sources");
                bus(st_idx[ch], 1'b0, 32'h0);
                check(rd, {28'h0, ~one}, "latched while disabled");
                pulse(ch, one);
                check({31'h0, chan_irq[ch]}, 32'h1, "enabled source");
                bus(st_idx[ch], 1'b0, 32'h0);
                check(rd, {28'h0, one}, "status before clear");
                @(negedge clk);
                check({31'h0, chan_irq[ch]}, 32'h0, "request after read");
                bus(st_idx[ch], 1'b0, 32'h0);
                check(rd, 32'h0000_0000, "status cleared");
            end
            bus(en_idx[ch], 1'b1, 32'h0);
        end
    endtask

    // Level interrupt through the block mask, then masked out.
    task automatic test_irq;
        bus(BLK_STATUS_IDX, 1'b1, 32'h0000_0007);
        bus(BLK_MASK_IDX, 1'b1, 32'h0000_0007);
        bus(ENABLE_IDX_CH1, 1'b1, 32'h0000_000F);
        pulse(1, 4'h8);
        repeat (3) @(negedge clk);
        check({31'h0, irq}, 32'h1, "irq raised");
        check({29'h0, chan_irq}, 32'h0000_0002, "only channel one");
        bus(STATUS_IDX_CH1, 1'b0, 32'h0);
        check(rd, 32'h0000_0008, "fifo change latched");
        bus(BLK_STATUS_IDX, 1'b1, 32'h0000_0007);
        @(negedge clk);
        check({31'h0, irq}, 32'h0, "irq cleared");
        bus(BLK_MASK_IDX, 1'b1, 32'h0000_0005);
        pulse(1, 4'h4);
        repeat (3) @(negedge clk);
        check({31'h0, chan_irq[1]}, 32'h1, "channel request");
        check({31'h0, irq}, 32'h0, "irq masked");
        bus(BLK_STATUS_IDX, 1'b0, 32'h0);
        check(rd, 32'h0000_0002, "block summary");
        bus(BLK_MASK_IDX, 1'b0, 32'h0);
        check(rd, 32'h0000_0005, "block mask readback");
        bus(STATUS_IDX_CH1, 1'b0, 32'h0);
    endtask

    // Prints the verdict and ends the run.
    task automatic final_report;
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence after a six-cycle reset.
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        test_reset();
        test_enable_rw();
        test_sources();
        test_read_race();
        test_irq();
        test_mid_reset();
        final_report();
    end

    // The tests need a few hundred cycles; this limit only catches a hung wait.
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
endmodule
